// file: hdl/pio_pkg.sv
// Purpose : shared constants for the port pin block
// Assumes : 25 pins, index 0 is P0.0 and index 24 is P3.0
// Notes   : peripheral signal order below is the matrix priority
package pio_pkg;

    // ************************************************
    // pin and signal counts
    // ************************************************
    localparam int NPIN = 25;               // P0.0 .. P3.0
    localparam int NSIG = 12;               // routable peripheral signals
    localparam int PIW  = 5;                // pin index width

    // ************************************************
    // fixed pin positions
    // ************************************************
    localparam logic [PIW-1:0] PIN_VREF   = 5'h00;  // P0.0
    localparam logic [PIW-1:0] PIN_OSC1   = 5'h02;  // P0.2
    localparam logic [PIW-1:0] PIN_OSC2   = 5'h03;  // P0.3
    localparam logic [PIW-1:0] PIN_SER_TX = 5'h04;  // P0.4
    localparam logic [PIW-1:0] PIN_SER_RX = 5'h05;  // P0.5
    localparam logic [PIW-1:0] PIN_DEBUG  = 5'h18;  // P3.0

    // ************************************************
    // peripheral signal indices, highest priority first
    // ************************************************
    localparam int SIG_SER_TX = 0;
    localparam int SIG_SER_RX = 1;
    localparam int SIG_SPI_CK = 2;
    localparam int SIG_SPI_MI = 3;
    localparam int SIG_SPI_MO = 4;
    localparam int SIG_SPI_SS = 5;
    localparam int SIG_SMB_DA = 6;
    localparam int SIG_SMB_CK = 7;
    localparam int SIG_CMP0   = 8;
    localparam int SIG_CMP1   = 9;
    localparam int SIG_CEX0   = 10;
    localparam int SIG_CEX1   = 11;

    // ************************************************
    // route select bit positions
    // ************************************************
    localparam int RS0_SER  = 0;
    localparam int RS0_SPI  = 2;
    localparam int RS0_SMB  = 3;
    localparam int RS0_CMP0 = 4;
    localparam int RS0_CMP1 = 6;
    localparam int RS1_CEX0 = 0;
    localparam int RS1_CEX1 = 1;

    // ************************************************
    // reset values
    // ************************************************
    localparam logic [NPIN-1:0] RST_PINS = 25'h0000000;
    localparam logic [NSIG-1:0] RST_SIGS = 12'h000;
    localparam logic [NPIN-1:0] RST_PULL = 25'h1ffffff;   // all pull-ups on

endpackage

// file: hdl/pio_pin_cell.sv
// Purpose : driver and pull-up decision for one pin
// Assumes : purely combinational, registered by the caller
// Notes   : output enable high means the pad is being driven
`timescale 1ns/1ps
module pio_pin_cell (
    // configuration
    input  wire logic analog_mode,    // 1 = analog, 0 = digital
    input  wire logic push_pull,      // 1 = push-pull
    input  wire logic force_od,       // bus pins forced open-drain
    input  wire logic matrix_en,      // routing matrix enabled
    input  wire logic pull_gdis,      // global pull-up disable
    // output value
    input  wire logic drive_req,      // pin acts as an output
    input  wire logic out_value,      // logic value to present
    // pad control
    output logic      pad_val,        // level driven when enabled
    output logic      pad_en,         // driver active
    output logic      pull_on         // weak pull-up active
);

    // ************************************************
    // driver and pull-up
    // ************************************************
    // pull-up follows the driver: it is only wanted while the pad floats
    always_comb begin
        pad_val = 1'b0;
        pad_en  = 1'b0;
        pull_on = 1'b0;
        // analog wins over the reset default: an analog pad stays fully quiet
        if (analog_mode) begin
            pull_on = 1'b0;                             // R2
        end else if (!matrix_en) begin
            pull_on = 1'b1;                             // R11
        end else begin
            if (drive_req && push_pull && !force_od) begin
                pad_en  = 1'b1;                         // R4
                pad_val = out_value;
            end else if (drive_req) begin
                pad_en  = !out_value;                   // R5
                pad_val = 1'b0;
            end
            // floating pin is pulled high unless pull_gdis is set, a driven pin never is
            pull_on = !pad_en && !pull_gdis;            // R6 R7 R8
        end
    end

endmodule

// file: hdl/pio_port.sv
// Functional notes
// R1 - input mode bit: 0 analog, 1 digital
// R2 - analog pin: no pull-up, driver, receiver
// R3 - analog pin always reads zero
// R4 - push-pull pin drives output value
// R5 - open-drain: only drives low
// R6 - floating digital pin gets weak pull-up
// R7 - pull-up off while driving low
// R8 - global disable turns all pull-ups off; code keeps them on while the matrix is disabled
// R9 - digital read returns sampled pad level
// R10 - pad state readable in every routing
// R11 - after reset: floating, pull-up, until enable
// R12 - skipped pin never claimed by matrix; code still gives skipped P0.4, P0.5 to the serial port
// R13 - only unskipped pins are matrix candidates
// R14 - software skips gpio, bypass, analog pins
// R15 - serial port fixed on P0.4, P0.5
// R16 - vref P0.0, oscillator P0.2, P0.3
// R17 - P3.0 is gpio and debug data
// R18 - route selects enable peripheral signals
// R19 - each signal takes lowest free pin
// R20 - serial bus pins always open-drain
// R21 - owned pin from peripheral, else latch
//
// Purpose : port pin cells plus priority routing matrix
// Assumes : pad inputs are asynchronous, all else on core_clk
// Notes   : every output is registered, so pads lag config by one cycle
`timescale 1ns/1ps
module pio_port
    import pio_pkg::*;
(
    // clock and reset
    input  wire logic            core_clk,
    input  wire logic            rst_n,
    // pin configuration
    input  wire logic [NPIN-1:0] pin_input_mode_bits,
    input  wire logic [NPIN-1:0] pin_output_mode_bits,
    input  wire logic [NPIN-1:0] crossbar_skip_bits,
    input  wire logic [NPIN-1:0] port_latch_out,
    // matrix control
    input  wire logic            pin_matrix_enable,
    input  wire logic            pullup_global_disable,
    input  wire logic [7:0]      peripheral_route_select_0,
    input  wire logic [7:0]      peripheral_route_select_1,
    input  wire logic [7:0]      peripheral_route_select_2,
    // peripheral side
    input  wire logic [NSIG-1:0] periph_out,
    input  wire logic [NSIG-1:0] periph_drive,
    output logic      [NSIG-1:0] periph_in,
    output logic      [NSIG-1:0] periph_placed,
    // two-wire debug data
    input  wire logic            debug_data_out,
    input  wire logic            debug_data_oe,
    output logic                 debug_data_in,
    // analog pin readiness
    output logic                 vref_pin_ready,
    output logic                 osc_first_ready,
    output logic                 osc_second_ready,
    // pads
    input  wire logic [NPIN-1:0] pad_in,
    output logic      [NPIN-1:0] pad_out,
    output logic      [NPIN-1:0] pad_oe,
    output logic      [NPIN-1:0] pad_pullup,
    output logic      [NPIN-1:0] pin_read
);

    // ************************************************
    // state
    // ************************************************
    typedef struct packed {
        logic [NPIN-1:0] sync1;        // first synchroniser stage
        logic [NPIN-1:0] sync2;        // second synchroniser stage
        logic [NPIN-1:0] pad_out;      // registered drive level
        logic [NPIN-1:0] pad_oe;       // registered driver enable
        logic [NPIN-1:0] pad_pullup;   // registered pull-up
        logic [NPIN-1:0] pin_read;     // port latch read value
        logic [NSIG-1:0] periph_in;    // peripheral input values
        logic [NSIG-1:0] placed;       // signal found a pin
        logic            debug_in;     // debug data read
        logic [2:0]      ana_ready;    // vref, osc1, osc2 ready
    } pio_state_s;

    pio_state_s state;                 // current state
    pio_state_s next_state;            // next state

    // ************************************************
    // routing matrix
    // ************************************************
    logic [NSIG-1:0] sig_en;               // enabled signals
    logic [NPIN-1:0] taken;                // pin claimed so far
    logic [NPIN-1:0] owned;                // pin owned by a signal
    logic [PIW-1:0]  sig_pin [NSIG];       // pin picked per signal
    logic [3:0]      pin_sig [NPIN];       // signal owning each pin
    logic            found;                // loop helper

    // signal enables from the route selects
    always_comb begin
        sig_en             = '0;
        sig_en[SIG_SER_TX] = peripheral_route_select_0[RS0_SER];   // R18
        sig_en[SIG_SER_RX] = peripheral_route_select_0[RS0_SER];
        sig_en[SIG_SPI_CK] = peripheral_route_select_0[RS0_SPI];
        sig_en[SIG_SPI_MI] = peripheral_route_select_0[RS0_SPI];
        sig_en[SIG_SPI_MO] = peripheral_route_select_0[RS0_SPI];
        sig_en[SIG_SPI_SS] = peripheral_route_select_0[RS0_SPI];
        sig_en[SIG_SMB_DA] = peripheral_route_select_0[RS0_SMB];
        sig_en[SIG_SMB_CK] = peripheral_route_select_0[RS0_SMB];
        sig_en[SIG_CMP0]   = peripheral_route_select_0[RS0_CMP0];
        sig_en[SIG_CMP1]   = peripheral_route_select_0[RS0_CMP1];
        sig_en[SIG_CEX0]   = peripheral_route_select_1[RS1_CEX0];
        sig_en[SIG_CEX1]   = peripheral_route_select_1[RS1_CEX1];
    end

    // priority walk: skipped pins look already taken to the matrix
    always_comb begin
        taken = crossbar_skip_bits;                              // R12 R13 R14
        owned = '0;
        found = 1'b0;
        for (int p = 0; p < NPIN; p++) begin
            pin_sig[p] = 4'h0;
        end
        for (int s = 0; s < NSIG; s++) begin
            sig_pin[s] = 5'h00;
        end
        // serial port pins are fixed, not taken by priority
        if (sig_en[SIG_SER_TX]) begin
            sig_pin[SIG_SER_TX]  = PIN_SER_TX;                   // R15
            sig_pin[SIG_SER_RX]  = PIN_SER_RX;
            taken[PIN_SER_TX]    = 1'b1;
            taken[PIN_SER_RX]    = 1'b1;
            owned[PIN_SER_TX]    = 1'b1;
            owned[PIN_SER_RX]    = 1'b1;
            pin_sig[PIN_SER_TX]  = 4'(SIG_SER_TX);
            pin_sig[PIN_SER_RX]  = 4'(SIG_SER_RX);
        end
        for (int s = SIG_SPI_CK; s < NSIG; s++) begin
            found = 1'b0;
            for (int p = 0; p < NPIN; p++) begin
                if (sig_en[s] && !found && !taken[p]) begin      // R19
                    found      = 1'b1;
                    taken[p]   = 1'b1;
                    owned[p]   = 1'b1;
                    sig_pin[s] = 5'(p);
                    pin_sig[p] = 4'(s);
                end
            end
        end
    end

    // ************************************************
    // pin cells
    // ************************************************
    logic [NPIN-1:0] cell_val;     // cell drive level
    logic [NPIN-1:0] cell_en;      // cell driver enable
    logic [NPIN-1:0] cell_pull;    // cell pull-up
    logic [NPIN-1:0] drive_req;    // pin wants to act as output
    logic [NPIN-1:0] out_value;    // value presented to the pin
    logic [NPIN-1:0] force_od;     // serial bus pins

    genvar g;
    generate
        for (g = 0; g < NPIN; g++) begin : g_pin
            // owner choice: peripheral, debug, or port latch
            always_comb begin
                force_od[g] = 1'b0;
                if (g == PIN_DEBUG && debug_data_oe) begin
                    drive_req[g] = 1'b1;                          // R17
                    out_value[g] = debug_data_out;
                end else if (owned[g] && pin_matrix_enable) begin
                    drive_req[g] = periph_drive[pin_sig[g]];      // R21
                    out_value[g] = periph_out[pin_sig[g]];
                    force_od[g]  = (pin_sig[g] == 4'(SIG_SMB_DA)) ||
                                   (pin_sig[g] == 4'(SIG_SMB_CK)); // R20
                end else begin
                    drive_req[g] = 1'b1;                          // R21
                    out_value[g] = port_latch_out[g];
                end
            end

            pio_pin_cell u_cell (
                .analog_mode (!pin_input_mode_bits[g]),           // R1
                .push_pull   (pin_output_mode_bits[g]),
                .force_od    (force_od[g]),
                .matrix_en   (pin_matrix_enable || (g == PIN_DEBUG && debug_data_oe)),
                .pull_gdis   (pullup_global_disable),
                .drive_req   (drive_req[g]),
                .out_value   (out_value[g]),
                .pad_val     (cell_val[g]),
                .pad_en      (cell_en[g]),
                .pull_on     (cell_pull[g])
            );
        end
    endgenerate

    // ************************************************
    // next state
    // ************************************************
    // reads come from the second synchroniser stage only
    always_comb begin
        next_state            = state;
        next_state.sync1      = pad_in;
        next_state.sync2      = state.sync1;
        next_state.pad_out    = cell_val;
        next_state.pad_oe     = cell_en;
        next_state.pad_pullup = cell_pull;
        // analog pins read zero, digital pins read the pad
        next_state.pin_read   = state.sync2 & pin_input_mode_bits;   // R3 R9 R10
        for (int s = 0; s < NSIG; s++) begin
            next_state.placed[s]    = sig_en[s] && pin_matrix_enable &&
                                      owned[sig_pin[s]] && (pin_sig[sig_pin[s]] == 4'(s));
            // an unplaced signal points at pin 0, so gate on placement, not enable
            next_state.periph_in[s] = next_state.placed[s] &&
                                      state.sync2[sig_pin[s]] &&
                                      pin_input_mode_bits[sig_pin[s]];
        end
        next_state.debug_in   = state.sync2[PIN_DEBUG] & pin_input_mode_bits[PIN_DEBUG];   // R17
        // analog functions need their pin analog and skipped
        next_state.ana_ready[0] = !pin_input_mode_bits[PIN_VREF] && crossbar_skip_bits[PIN_VREF];  // R16
        next_state.ana_ready[1] = !pin_input_mode_bits[PIN_OSC1] && crossbar_skip_bits[PIN_OSC1];
        next_state.ana_ready[2] = !pin_input_mode_bits[PIN_OSC2] && crossbar_skip_bits[PIN_OSC2];
    end

    // register update, synchronous reset to floating pins with pull-ups
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state            <= '0;
            state.pad_pullup <= RST_PULL;                    // R11
            state.pin_read   <= RST_PINS;
            state.periph_in  <= RST_SIGS;
        end else begin
            state <= next_state;
        end
    end

    // ************************************************
    // outputs
    // ************************************************
    assign pad_out          = state.pad_out;
    assign pad_oe           = state.pad_oe;
    assign pad_pullup       = state.pad_pullup;
    assign pin_read         = state.pin_read;
    assign periph_in        = state.periph_in;
    assign periph_placed    = state.placed;
    assign debug_data_in    = state.debug_in;
    assign vref_pin_ready   = state.ana_ready[0];
    assign osc_first_ready  = state.ana_ready[1];
    assign osc_second_ready = state.ana_ready[2];

    // route select 2, bits 7:2 of select 1 and bits 7, 5 and 1 of select 0 are accepted but unused here
    logic unused_sel;
    assign unused_sel = ^{peripheral_route_select_2, peripheral_route_select_1[7:2],
                          peripheral_route_select_0[7], peripheral_route_select_0[5],
                          peripheral_route_select_0[1]};

endmodule

// file: dv/pio_port_asserts.sv
// Purpose : port-level checker for the pin block
// Assumes : one clock, registered outputs lag config by one edge and pad levels by three
// Notes   : pin 24 is masked where the debug driver may override the cell
`timescale 1ns/1ps
module pio_port_asserts
    import pio_pkg::*;
(
    // clock and reset
    input wire logic            core_clk, rst_n,
    // configuration
    input wire logic [NPIN-1:0] pin_input_mode_bits, pin_output_mode_bits, crossbar_skip_bits, port_latch_out,
    input wire logic            pin_matrix_enable, pullup_global_disable,
    input wire logic [7:0]      peripheral_route_select_0, peripheral_route_select_1, peripheral_route_select_2,
    // peripheral and debug side
    input wire logic [NSIG-1:0] periph_out, periph_drive, periph_in, periph_placed,
    input wire logic            debug_data_out, debug_data_oe, debug_data_in,
    // analog readiness
    input wire logic            vref_pin_ready, osc_first_ready, osc_second_ready,
    // pads
    input wire logic [NPIN-1:0] pad_in, pad_out, pad_oe, pad_pullup, pin_read
);
    // ****************************************
    // helper terms
    // ****************************************
    localparam logic [NPIN-1:0] NO_DBG = 25'h0ffffff;   // debug oe may drive pin 24
    wire logic [NPIN-1:0] pp_pins = pin_input_mode_bits & pin_output_mode_bits;   // digital push-pull
    wire logic [NPIN-1:0] od_pins = pin_input_mode_bits & ~pin_output_mode_bits;  // digital open-drain
    // plain gpio only: routing or debug would legally change the pad
    wire logic quiet = ((peripheral_route_select_0 | peripheral_route_select_1 | peripheral_route_select_2) == 8'h00)
                       && !debug_data_oe;
    wire logic [2:0] ready_cause = {~pin_input_mode_bits[PIN_VREF] & crossbar_skip_bits[PIN_VREF],
        ~pin_input_mode_bits[PIN_OSC1] & crossbar_skip_bits[PIN_OSC1],
        ~pin_input_mode_bits[PIN_OSC2] & crossbar_skip_bits[PIN_OSC2]};
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // three clean edges refill both sync stages and the read register
    sequence s_run3;
        rst_n ##1 rst_n ##1 rst_n;
    endsequence
    // ****************************************
    // assertions
    // ****************************************
    a_analog_quiet : assert property ($past(rst_n) |->
        ((pad_oe | pad_pullup) & ~$past(pin_input_mode_bits) & NO_DBG) == '0) else $error("analog pin active");
    a_analog_zero : assert property ($past(rst_n) |->
        (pin_read & ~$past(pin_input_mode_bits)) == '0) else $error("analog pin read not zero");
    a_push_pull : assert property ($past(rst_n && pin_matrix_enable && quiet) |->
        ((pad_oe & $past(pp_pins)) == $past(pp_pins)) && (((pad_out ^ $past(port_latch_out)) & $past(pp_pins)) == '0))
        else $error("push-pull pin wrong");
    a_od_high_off : assert property ($past(rst_n) |->
        (pad_oe & pad_out & $past(od_pins) & NO_DBG) == '0) else $error("open-drain pin drove high");
    a_od_low_drive : assert property ($past(rst_n && pin_matrix_enable && quiet) |->
        (pad_oe & $past(od_pins)) == $past(od_pins & ~port_latch_out)) else $error("open-drain enable wrong");
    a_pull_low_off : assert property ((pad_pullup & pad_oe & ~pad_out) == '0)
        else $error("pull-up on while driving low");
    a_float_pull : assert property ($past(rst_n && pin_matrix_enable && quiet) |->
        (pad_pullup & ~pad_oe & $past(pin_input_mode_bits))
        == ({NPIN{!$past(pullup_global_disable)}} & ~pad_oe & $past(pin_input_mode_bits))) else $error("pull-up wrong");
    a_matrix_off : assert property ($past(rst_n && !pin_matrix_enable && !debug_data_oe) |-> pad_oe == '0
        && periph_placed == '0 && (pad_pullup & $past(pin_input_mode_bits)) == $past(pin_input_mode_bits))
        else $error("pin active with matrix off");
    a_serial_fixed : assert property ($past(rst_n && pin_matrix_enable && peripheral_route_select_0[RS0_SER]) |->
        periph_placed[SIG_SER_RX:SIG_SER_TX] == 2'b11) else $error("serial port not placed");
    a_serial_tx : assert property ($past(rst_n && pin_matrix_enable && peripheral_route_select_0[RS0_SER]
        && periph_drive[SIG_SER_TX] && pp_pins[PIN_SER_TX]) |-> pad_oe[PIN_SER_TX]
        && pad_out[PIN_SER_TX] == $past(periph_out[SIG_SER_TX])) else $error("serial tx pin wrong");
    a_read_sync : assert property (s_run3 |=>
        (pin_read & $past(pin_input_mode_bits)) == ($past(pad_in, 3) & $past(pin_input_mode_bits)))
        else $error("pin read not pad level");
    a_ready_flags : assert property ($past(rst_n) |->
        {vref_pin_ready, osc_first_ready, osc_second_ready} == $past(ready_cause)) else $error("ready flags wrong");
endmodule
bind pio_port pio_port_asserts u_chk (.core_clk, .rst_n, .pin_input_mode_bits, .pin_output_mode_bits,
    .crossbar_skip_bits, .port_latch_out, .pin_matrix_enable, .pullup_global_disable, .peripheral_route_select_0,
    .peripheral_route_select_1, .peripheral_route_select_2, .periph_out, .periph_drive, .periph_in,
    .periph_placed, .debug_data_out, .debug_data_oe, .debug_data_in, .vref_pin_ready, .osc_first_ready,
    .osc_second_ready, .pad_in, .pad_out, .pad_oe, .pad_pullup, .pin_read);

// file: dv/pio_pad_model.sv
// Purpose : board side of the pads
// Assumes : bench never drives a pin the device drives
// Notes   : undriven pins without pull-up toggle so no stale level passes
`timescale 1ns/1ps
module pio_pad_model
    import pio_pkg::*;
(
    // clock
    input  wire logic            core_clk,
    // device pad control
    input  wire logic [NPIN-1:0] pad_out,
    input  wire logic [NPIN-1:0] pad_oe,
    input  wire logic [NPIN-1:0] pad_pullup,
    // external driver
    input  wire logic [NPIN-1:0] ext_en,
    input  wire logic [NPIN-1:0] ext_val,
    // resolved level
    output logic      [NPIN-1:0] pad_in
);
    logic [NPIN-1:0] noise = '0;   // level of a floating line
    // floating lines move off the sampling edge
    always @(negedge core_clk) begin
        noise <= ~noise;
    end
    // device driver wins, then board driver, then weak pull-up
    always_comb begin
        pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val) | (~pad_oe & ~ext_en & (pad_pullup | noise));
    end
endmodule

// file: dv/pio_port_tb_top.sv
// Purpose : directed bench for the port pin block
// Assumes : inputs change on the falling edge, outputs settle within 4 cycles
// Notes   : expectations are worked out from the pin settings
`timescale 1ns/1ps
module pio_port_tb_top
    import pio_pkg::*;
;
    // ****************************************
    // stimulus and observed signals
    // ****************************************
    logic            core_clk = 1'b0;   // 50 ns period
    logic            rst_n = 1'b0;      // held low at start
    logic [NPIN-1:0] in_mode = '1, out_mode = '1, skip = '1, latch = '0, ext_en = '0, ext_val = '0;
    logic            en = 1'b0, gdis = 1'b0, dbg_out = 1'b0, dbg_oe = 1'b0;
    logic [7:0]      rs0 = 8'h00, rs1 = 8'h00, rs2 = 8'h00;
    logic [NSIG-1:0] p_out = '0, p_drv = '0, p_in, p_placed;
    logic            dbg_in, rdy_v, rdy_o1, rdy_o2;
    logic [NPIN-1:0] pad_in, pad_out, pad_oe, pad_pullup, pin_read;
    int              fail_count = 0, comparisons = 0;
    initial begin
        forever #25 core_clk = ~core_clk;
    end
    pio_port uut (.core_clk(core_clk), .rst_n(rst_n), .pin_input_mode_bits(in_mode), .pin_output_mode_bits(out_mode),
        .crossbar_skip_bits(skip), .port_latch_out(latch), .pin_matrix_enable(en), .pullup_global_disable(gdis),
        .peripheral_route_select_0(rs0), .peripheral_route_select_1(rs1), .peripheral_route_select_2(rs2),
        .periph_out(p_out), .periph_drive(p_drv), .periph_in(p_in), .periph_placed(p_placed),
        .debug_data_out(dbg_out), .debug_data_oe(dbg_oe), .debug_data_in(dbg_in), .vref_pin_ready(rdy_v),
        .osc_first_ready(rdy_o1), .osc_second_ready(rdy_o2), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
        .pad_pullup(pad_pullup), .pin_read(pin_read));
    pio_pad_model u_pads (.core_clk(core_clk), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup),
        .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));
    // ****************************************
    // tasks
    // ****************************************
    // one comparison of a pin or signal vector
    task automatic check(input logic [NPIN-1:0] got, input logic [NPIN-1:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // let n rising edges pass, then stand on the falling edge
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // hang guard: far above the directed run length
    initial begin
        repeat (5000) @(posedge core_clk);
        fail_count++;
        tally_and_finish();
    end
    // ****************************************
    // directed sequence
    // ****************************************
    initial begin
        step(12);
        check(pad_oe, '0);
        check(pad_pullup, '1);
        rst_n = 1'b1;
        latch = '1;
        step(4);
        check(pad_oe, '0);
        check(pin_read, '1);
        // gpio, pins 0-11 push-pull, pins 12-24 open-drain, all skipped
        en = 1'b1;
        out_mode = 25'h0000fff;
        latch = 25'h0a5a5a5;
        step(4);
        check(pad_oe, out_mode | ~latch);
        check(pad_out & pad_oe, latch & out_mode);
        check(pad_pullup, ~(out_mode | ~latch));
        check(pin_read, latch);
        ext_en = 25'h000a000;   // pull two released lines low from outside
        step(4);
        check(pin_read, latch & ~ext_en);
        gdis = 1'b1;
        step(2);
        check(pad_pullup, '0);
        // analog on the reference and oscillator pins
        gdis = 1'b0;
        in_mode = 25'h1fffff0;
        ext_en = 25'h000000f;
        ext_val = '1;
        step(4);
        check((pad_oe | pad_pullup) & 25'h000000f, '0);
        check(pin_read & 25'h000000f, '0);
        check({22'h0, rdy_v, rdy_o1, rdy_o2}, 25'h0000007);
        skip = 25'h1fffff2;
        step(2);
        check({22'h0, rdy_v, rdy_o1, rdy_o2}, 25'h0000000);
        // serial port plus spi with only pins 1, 7, 9, 10 free
        in_mode = '1;
        out_mode = '1;
        latch = '0;
        skip = 25'h1fff97d;
        rs0 = 8'h05;
        p_out = 12'h015;
        p_drv = 12'hff5;
        ext_en = 25'h0000080;
        ext_val = '0;
        step(4);
        check({13'h0, p_placed}, 25'h000003f);
        check(pad_oe, 25'h1ffff5f);
        check(pad_out & pad_oe, 25'h0000212);
        check(pin_read, 25'h0000232);
        check({13'h0, p_in}, 25'h0000017);
        // serial bus with one free pin: data placed, clock left out
        rs0 = 8'h08;
        skip = 25'h1fffffd;
        p_out = 12'h040;
        p_drv = '1;
        ext_en = '0;
        step(4);
        check({13'h0, p_placed}, 25'h0000040);
        check(pad_oe & 25'h0000002, 25'h0000000);
        p_out = 12'h000;
        step(2);
        check((pad_oe & ~pad_out) & 25'h0000002, 25'h0000002);
        // comparators and capture outputs on three free pins, last one left out
        rs0 = 8'h50;
        rs1 = 8'h03;
        skip = 25'h1ffff8f;
        latch = 25'h0000001;
        step(4);
        check({13'h0, p_placed}, 25'h0000700);
        check({13'h0, p_in}, 25'h0000000);
        // matrix off, debug driver still owns its pin
        rs0 = 8'h00;
        rs1 = 8'h00;
        en = 1'b0;
        dbg_oe = 1'b1;
        dbg_out = 1'b1;
        step(4);
        check(pad_oe, 25'h1000000);
        check(pad_out & pad_oe, 25'h1000000);
        check({24'h0, dbg_in}, 25'h0000001);
        // second reset in mid-run
        dbg_oe = 1'b0;
        en = 1'b1;
        rst_n = 1'b0;
        step(2);
        check(pad_oe, '0);
        check(pad_pullup, '1);
        rst_n = 1'b1;
        step(2);
        check(pad_oe, '1);
        check(pad_pullup, '0);
        tally_and_finish();
    end
endmodule
